// File: rtl/mdseq_pkg.sv
// Shared constants and types for the multiply/divide instruction sequencer
package mdseq_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int DATA_W = 16;
    localparam int CODE_W = 3;
    localparam int CNT_W  = 4;

    // ************************************************************
    // Instruction codes
    // ************************************************************
    localparam logic [CODE_W-1:0] CODE_MUL_START  = 3'h0;
    localparam logic [CODE_W-1:0] CODE_MAC_NEXT   = 3'h2;
    localparam logic [CODE_W-1:0] CODE_DIV_START  = 3'h4;
    localparam logic [CODE_W-1:0] CODE_LOAD_FRAC  = 3'h5;
    localparam logic [CODE_W-1:0] CODE_LOAD_INT   = 3'h6;
    localparam logic [CODE_W-1:0] CODE_READ       = 3'h7;

    // ************************************************************
    // Operation lengths in clock pulses, counted from the start code
    // ************************************************************
    localparam logic [CNT_W-1:0] MUL_PULSES = 4'h8;
    localparam logic [CNT_W-1:0] DIV_PULSES = 4'h3;

    // ************************************************************
    // Operand load sequence: first operand, upper result, lower result
    // ************************************************************
    localparam logic [1:0] LD_X    = 2'h0;
    localparam logic [1:0] LD_Z    = 2'h1;
    localparam logic [1:0] LD_W    = 2'h2;
    localparam logic [1:0] LD_FULL = 2'h3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_RST  = 4'h0;

    typedef enum logic [2:0] {
        MDSEQ_IDLE,
        MDSEQ_RUN,
        MDSEQ_LAST,
        MDSEQ_RD_HI,
        MDSEQ_RD_LO,
        MDSEQ_SWAP
    } mdseq_state_type;

endpackage

// File: rtl/mdseq_arith.sv
// Combinational multiply-accumulate and divide arithmetic with range checks
`timescale 1ns/10ps

module mdseq_arith #(
    parameter int DW = 16
) (
    input  wire logic [DW-1:0]   x_op,
    input  wire logic [DW-1:0]   y_op,
    input  wire logic [2*DW-1:0] acc_in,
    input  wire logic            frac,
    output logic      [2*DW-1:0] mac_out,
    output logic                 mac_ovf,
    output logic      [DW-1:0]   quo_out,
    output logic      [DW-1:0]   rem_out,
    output logic                 div_ovf
);

    logic signed [2*DW-1:0] prod;
    logic signed [2*DW+1:0] sum;
    logic signed [2*DW+1:0] dividend;
    logic signed [2*DW+1:0] divisor;
    logic signed [2*DW+1:0] quo;
    logic signed [2*DW+1:0] rem;

    // ************************************************************
    // Multiply and accumulate
    // ************************************************************
    always_comb begin
        prod = $signed(x_op) * $signed(y_op);
        // Fractional products are normalised one place left; LSB becomes 0
        if (frac) begin
            sum = $signed({prod[2*DW-1], prod, 1'b0});
        end else begin
            sum = $signed({{2{prod[2*DW-1]}}, prod});
        end
        sum     = sum + $signed({{2{acc_in[2*DW-1]}}, acc_in});
        mac_out = sum[2*DW-1:0];
        mac_ovf = (sum[2*DW+1:2*DW-1] != 3'b000) && (sum[2*DW+1:2*DW-1] != 3'b111);
    end

    // ************************************************************
    // Divide: quotient scaled so both modes land in a signed 16-bit word
    // ************************************************************
    always_comb begin
        if (frac) begin
            dividend = $signed({acc_in[2*DW-1], acc_in, 1'b0});
        end else begin
            dividend = $signed({{2{acc_in[2*DW-1]}}, acc_in});
        end
        divisor = $signed({{(DW+2){x_op[DW-1]}}, x_op});
        if (x_op == '0) begin
            // Zero divisor cannot produce a quotient; flag it and keep result zero
            quo = '0;
            rem = '0;
        end else begin
            quo = dividend / divisor;
            rem = dividend % divisor;
        end
        quo_out = quo[DW-1:0];
        rem_out = rem[DW-1:0];
        div_ovf = (x_op == '0) ||
                  ((quo[2*DW+1:DW-1] != '0) && (quo[2*DW+1:DW-1] != '1));
    end

endmodule // mdseq_arith

// File: rtl/mdseq_core.sv
// Instruction-sequenced 16-bit multiplier/divider with accumulation
// Behaviour
// [RULE1] Host changes code and gate while clock high
// [RULE2] Overflow output set when upper half driven
// [RULE3] Held read code swaps result halves each clock
// [RULE4] Gated code six loads first operand
// [RULE5] Gated read code drives the data bus
// [RULE6] Read with gate high waits for gate low
// [RULE7] Gate high blocks operand load and bus drive
// [RULE8] Read in final multiply slot gives halves next
// [RULE9] Post-multiply code six loads operand, enters final
// [RULE10] Final state code two loads operand, restarts accumulate
// [RULE11] Multiply takes eight pulses after second operand
// [RULE12] Preloaded 32-bit constant is added to product
// [RULE13] Divide 32-bit result pair by first operand
// [RULE14] Reads after divide give quotient then remainder
// [RULE15] Sum of products accumulates without intermediate reads
// [RULE16] Waiting states hold while gate high
// [RULE17] Overflow cleared at start, set on range loss
// [RULE18] Code five loads fractional, code six integer
// [RULE19] Code and gate sampled on rising clock edge
`timescale 1ns/10ps

module mdseq_core #(
    parameter int DW = 16
) (
    input  wire logic          clk_sys,
    input  wire logic          resetn,
    input  wire logic [2:0]    instruction_code,
    input  wire logic          go_n,
    input  wire logic [DW-1:0] bus_in,
    output logic      [DW-1:0] bus_out,
    output logic               bus_oe,
    output logic               range_exceeded_flag
);

    // ************************************************************
    // State
    // ************************************************************
    mdseq_pkg::mdseq_state_type state_r, state_nxt;
    logic [mdseq_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [1:0]                  ld_idx_r, ld_idx_nxt;
    logic [DW-1:0]               x_r, x_nxt;
    logic [DW-1:0]               x_op_r, x_op_nxt;
    logic [DW-1:0]               y_r, y_nxt;
    logic [DW-1:0]               z_r, z_nxt;
    logic [DW-1:0]               w_r, w_nxt;
    logic                        frac_r, frac_nxt;
    logic                        div_r, div_nxt;
    logic                        ovf_pend_r, ovf_pend_nxt;
    logic                        flag_r, flag_nxt;
    logic [DW-1:0]               bus_out_r, bus_out_nxt;
    logic                        bus_oe_r, bus_oe_nxt;

    // ************************************************************
    // Decode and arithmetic results
    // ************************************************************
    logic                        gate;
    logic                        is_read;
    logic [mdseq_pkg::CNT_W-1:0] run_end;
    logic [2*DW-1:0]             mac_out;
    logic                        mac_ovf;
    logic [DW-1:0]               quo_out;
    logic [DW-1:0]               rem_out;
    logic                        div_ovf;

    // ************************************************************
    // Decoding
    // ************************************************************
    // Shared by the bus drive and the overlapped X reload, so the
    // gate qualifies both in exactly the same way
    function automatic logic code_taken(input logic       gate_on,
                                        input logic [2:0] code,
                                        input logic [2:0] want);
        return gate_on && (code == want);
    endfunction

    // Code and gate are driven by same-clock logic that only moves them
    // while the clock is high, so they are taken straight at the edge.
    assign gate    = !go_n;                                              // see [RULE1]
    assign is_read = code_taken(gate, instruction_code, mdseq_pkg::CODE_READ); // see [RULE19]
    assign run_end = div_r ? mdseq_pkg::DIV_PULSES : mdseq_pkg::MUL_PULSES;

    // ************************************************************
    // Arithmetic on the operand snapshots
    // ************************************************************
    // A reload of X cannot disturb a running operation: the unit only sees x_op_r
    mdseq_arith #(
        .DW      (DW)
    ) u_arith (
        .x_op    (x_op_r),
        .y_op    (y_r),
        .acc_in  ({z_r, w_r}),
        .frac    (frac_r),
        .mac_out (mac_out),
        .mac_ovf (mac_ovf),
        .quo_out (quo_out),
        .rem_out (rem_out),
        .div_ovf (div_ovf)
    );

    // ************************************************************
    // Sequencer next-state logic
    // ************************************************************
    always_comb begin
        // Registers hold by default, except the bus output, which takes Z; the bus is driven one slot per read
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        ld_idx_nxt   = ld_idx_r;
        x_nxt        = x_r;
        x_op_nxt     = x_op_r;
        y_nxt        = y_r;
        z_nxt        = z_r;
        w_nxt        = w_r;
        frac_nxt     = frac_r;
        div_nxt      = div_r;
        ovf_pend_nxt = ovf_pend_r;
        flag_nxt     = flag_r;
        bus_out_nxt  = z_r;
        bus_oe_nxt   = 1'b0;

        // Code six reloads the first operand in every state but idle; the running
        // operation works from its own snapshot, so loading can overlap.
        if (code_taken(gate, instruction_code, mdseq_pkg::CODE_LOAD_INT) &&
            (state_r != mdseq_pkg::MDSEQ_IDLE)) begin
            x_nxt = bus_in;                                              // see [RULE4] [RULE7]
        end
        // Outside the read states a gated read code still drives the bus
        if (is_read) begin
            bus_oe_nxt = 1'b1;                                           // see [RULE5] [RULE7]
        end

        case (state_r)
            mdseq_pkg::MDSEQ_IDLE: begin
                if (gate) begin                                          // see [RULE16]
                    case (instruction_code)
                        mdseq_pkg::CODE_LOAD_INT,
                        mdseq_pkg::CODE_LOAD_FRAC: begin
                            // Successive loads fill X, then Z, then W
                            frac_nxt = (instruction_code == mdseq_pkg::CODE_LOAD_FRAC); // see [RULE18]
                            case (ld_idx_r)
                                mdseq_pkg::LD_X: x_nxt = bus_in;        // see [RULE4]
                                mdseq_pkg::LD_Z: z_nxt = bus_in;        // see [RULE12]
                                mdseq_pkg::LD_W: w_nxt = bus_in;        // see [RULE12]
                                default:         x_nxt = bus_in;
                            endcase
                            // Index stops at full, so a fourth load rewrites X
                            if (ld_idx_r != mdseq_pkg::LD_FULL) begin
                                ld_idx_nxt = ld_idx_r + 2'h1;
                            end
                        end
                        mdseq_pkg::CODE_MUL_START: begin
                            y_nxt        = bus_in;
                            x_op_nxt     = x_r;
                            div_nxt      = 1'b0;
                            ovf_pend_nxt = 1'b0;                         // see [RULE17]
                            flag_nxt     = 1'b0;
                            cnt_nxt      = mdseq_pkg::CNT_RST;
                            state_nxt    = mdseq_pkg::MDSEQ_RUN;
                            // Only a full X, Z, W preload is kept as the addend
                            if (ld_idx_r != mdseq_pkg::LD_FULL) begin   // see [RULE12]
                                z_nxt = mdseq_pkg::DATA_RST;
                                w_nxt = mdseq_pkg::DATA_RST;
                            end
                            ld_idx_nxt   = mdseq_pkg::LD_X;
                        end
                        mdseq_pkg::CODE_DIV_START: begin
                            // Z must already hold the upper dividend half
                            w_nxt        = bus_in;                       // see [RULE13]
                            x_op_nxt     = x_r;
                            div_nxt      = 1'b1;
                            ovf_pend_nxt = 1'b0;                         // see [RULE17]
                            flag_nxt     = 1'b0;
                            cnt_nxt      = mdseq_pkg::CNT_RST;
                            state_nxt    = mdseq_pkg::MDSEQ_RUN;
                            ld_idx_nxt   = mdseq_pkg::LD_X;
                        end
                        mdseq_pkg::CODE_READ: begin
                            bus_out_nxt  = z_r;
                            flag_nxt     = ovf_pend_r;                   // see [RULE2]
                            state_nxt    = mdseq_pkg::MDSEQ_RD_HI;
                        end
                        default: begin
                            // Codes 1 and 3 do nothing; code 2 only counts in the final slot
                        end
                    endcase
                end
            end
            mdseq_pkg::MDSEQ_RUN: begin
                // The count runs on with the gate high, so an operation has fixed length
                cnt_nxt = cnt_r + 4'h1;
                // The slot before the last is the post-multiply step; any
                // code, including an operand reload, moves on to the final slot.
                if (cnt_r == run_end - 4'h2) begin                       // see [RULE9] [RULE11]
                    state_nxt = mdseq_pkg::MDSEQ_LAST;
                    if (div_r) begin
                        z_nxt        = quo_out;                          // see [RULE13] [RULE14]
                        w_nxt        = rem_out;
                        ovf_pend_nxt = ovf_pend_r | div_ovf;             // see [RULE17]
                    end else begin
                        z_nxt        = mac_out[2*DW-1:DW];               // see [RULE12] [RULE15]
                        w_nxt        = mac_out[DW-1:0];
                        ovf_pend_nxt = ovf_pend_r | mac_ovf;             // see [RULE17]
                    end
                end
            end
            mdseq_pkg::MDSEQ_LAST: begin
                if (gate) begin                                          // see [RULE16]
                    if (instruction_code == mdseq_pkg::CODE_READ) begin
                        bus_out_nxt = z_r;                               // see [RULE8]
                        flag_nxt    = ovf_pend_r;                        // see [RULE2]
                        state_nxt   = mdseq_pkg::MDSEQ_RD_HI;
                    end else if ((instruction_code == mdseq_pkg::CODE_MAC_NEXT) &&
                                 !div_r) begin
                        // Next product accumulates onto the running total
                        y_nxt     = bus_in;                              // see [RULE10] [RULE15]
                        x_op_nxt  = x_r;
                        cnt_nxt   = mdseq_pkg::CNT_RST;
                        state_nxt = mdseq_pkg::MDSEQ_RUN;
                    end else begin
                        // No rounding step: code five, like any other, returns to idle
                        state_nxt = mdseq_pkg::MDSEQ_IDLE;
                    end
                end
            end
            mdseq_pkg::MDSEQ_RD_HI: begin
                // Gate high holds the read; any other gated code ends it
                if (gate) begin                                          // see [RULE6] [RULE16]
                    if (instruction_code == mdseq_pkg::CODE_READ) begin
                        bus_out_nxt = w_r;                               // see [RULE8] [RULE14]
                        state_nxt   = mdseq_pkg::MDSEQ_RD_LO;
                    end else begin
                        state_nxt   = mdseq_pkg::MDSEQ_IDLE;
                    end
                end
            end
            mdseq_pkg::MDSEQ_RD_LO,
            mdseq_pkg::MDSEQ_SWAP: begin
                if (gate) begin                                          // see [RULE16]
                    if (instruction_code == mdseq_pkg::CODE_READ) begin
                        // Halves trade places every clock the read code stays
                        z_nxt       = w_r;                               // see [RULE3]
                        w_nxt       = z_r;
                        bus_out_nxt = w_r;
                        state_nxt   = mdseq_pkg::MDSEQ_SWAP;
                    end else begin
                        state_nxt   = mdseq_pkg::MDSEQ_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = mdseq_pkg::MDSEQ_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Reset leaves integer mode and an empty load sequence
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r    <= mdseq_pkg::MDSEQ_IDLE;
            cnt_r      <= mdseq_pkg::CNT_RST;
            ld_idx_r   <= mdseq_pkg::LD_X;
            x_r        <= mdseq_pkg::DATA_RST;
            x_op_r     <= mdseq_pkg::DATA_RST;
            y_r        <= mdseq_pkg::DATA_RST;
            z_r        <= mdseq_pkg::DATA_RST;
            w_r        <= mdseq_pkg::DATA_RST;
            frac_r     <= 1'b0;
            div_r      <= 1'b0;
            ovf_pend_r <= 1'b0;
            flag_r     <= 1'b0;
            bus_out_r  <= mdseq_pkg::DATA_RST;
            bus_oe_r   <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            ld_idx_r   <= ld_idx_nxt;
            x_r        <= x_nxt;
            x_op_r     <= x_op_nxt;
            y_r        <= y_nxt;
            z_r        <= z_nxt;
            w_r        <= w_nxt;
            frac_r     <= frac_nxt;
            div_r      <= div_nxt;
            ovf_pend_r <= ovf_pend_nxt;
            flag_r     <= flag_nxt;
            bus_out_r  <= bus_out_nxt;
            bus_oe_r   <= bus_oe_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign bus_out             = bus_out_r;
    assign bus_oe              = bus_oe_r;
    assign range_exceeded_flag = flag_r;

endmodule // mdseq_core

// File: dv/mdseq_core_props.sv
// Concurrent checks on the sequencer's bus, gate and overflow ports
`timescale 1ns/10ps

module mdseq_core_props #(
    parameter int DW = 16
) (
    input wire logic          clk_sys,
    input wire logic          resetn,
    input wire logic [2:0]    instruction_code,
    input wire logic          go_n,
    input wire logic [DW-1:0] bus_in,
    input wire logic [DW-1:0] bus_out,
    input wire logic          bus_oe,
    input wire logic          range_exceeded_flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ************************************************************
    // Read requests as seen on the code and gate lines
    // ************************************************************
    sequence s_gated_read;
        instruction_code == mdseq_pkg::CODE_READ && !go_n;
    endsequence

    sequence s_blocked_read;
        instruction_code == mdseq_pkg::CODE_READ && go_n;
    endsequence

    // ************************************************************
    // Assertions
    // ************************************************************
    a_read_drives_bus: assert property (s_gated_read |=> bus_oe)
        else $error("bus not driven after a gated read");
    a_no_read_quiet: assert property (
        !(instruction_code == mdseq_pkg::CODE_READ && !go_n) |=> !bus_oe)
        else $error("bus driven without a gated read");
    a_gate_blocks_bus: assert property (go_n |=> !bus_oe)
        else $error("bus driven while the gate was high");
    a_held_read_waits: assert property (
        s_blocked_read ##1 s_gated_read |=> bus_oe && !$past(bus_oe))
        else $error("held read did not wait for the gate");
    a_two_reads_pair: assert property (
        s_gated_read ##1 s_gated_read |=> bus_oe && $past(bus_oe))
        else $error("back to back reads did not give two slots");
    a_flag_with_upper: assert property ($rose(range_exceeded_flag) |->
        bus_oe && $past(instruction_code) == mdseq_pkg::CODE_READ && !$past(go_n))
        else $error("overflow rose outside an upper half read slot");
    a_flag_clear_cause: assert property ($fell(range_exceeded_flag) |->
        !$past(go_n) && ($past(instruction_code) == mdseq_pkg::CODE_MUL_START
        || $past(instruction_code) == mdseq_pkg::CODE_DIV_START))
        else $error("overflow cleared without an operation start");
    a_gate_holds_flag: assert property (go_n |=> $stable(range_exceeded_flag))
        else $error("overflow changed while the gate was high");
endmodule // mdseq_core_props

bind mdseq_core mdseq_core_props #(.DW(DW)) u_mdseq_core_props (
    .clk_sys             (clk_sys),
    .resetn              (resetn),
    .instruction_code    (instruction_code),
    .go_n                (go_n),
    .bus_in              (bus_in),
    .bus_out             (bus_out),
    .bus_oe              (bus_oe),
    .range_exceeded_flag (range_exceeded_flag)
);

// File: dv/mdseq_host.sv
// Host model: a same-clock bus master driving code, gate and data lines
`timescale 1ns/10ps

module mdseq_host (
    input  wire logic   clk_sys,
    output logic [2:0]  instruction_code,
    output logic        go_n,
    output logic [15:0] bus_in
);
    initial begin
        instruction_code = 3'h1;
        go_n             = 1'b1;
        bus_in           = 16'h0000;
    end

    // Lines move just after the rising edge, while the clock is high
    task automatic drive(input logic [2:0] code, input logic gate_n, input logic [15:0] data);
        @(posedge clk_sys);
        instruction_code <= code;
        go_n             <= gate_n;
        // Released bus toggles so a stale value can never pass as data
        if (code == mdseq_pkg::CODE_READ || gate_n) begin
            bus_in <= ~bus_in;
        end else begin
            bus_in <= data;
        end
    endtask
endmodule // mdseq_host

// File: dv/mdseq_bench.sv
// Self-checking testbench for the multiply/divide instruction sequencer
`timescale 1ns/10ps

module mdseq_bench;
    logic        clk_sys;
    logic        resetn;
    logic [2:0]  instruction_code;
    logic        go_n;
    logic [15:0] bus_in;
    logic [15:0] bus_out;
    logic        bus_oe;
    logic        range_exceeded_flag;
    int          fails;
    int          comparisons;

    mdseq_core #(.DW(mdseq_pkg::DATA_W)) u_mdseq_core (
        .clk_sys             (clk_sys),
        .resetn              (resetn),
        .instruction_code    (instruction_code),
        .go_n                (go_n),
        .bus_in              (bus_in),
        .bus_out             (bus_out),
        .bus_oe              (bus_oe),
        .range_exceeded_flag (range_exceeded_flag)
    );

    mdseq_host u_mdseq_host (
        .clk_sys          (clk_sys),
        .instruction_code (instruction_code),
        .go_n             (go_n),
        .bus_in           (bus_in)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ************************************************************
    // Shared helpers
    // ************************************************************
    function automatic logic [31:0] prod(input logic [15:0] a, input logic [15:0] b);
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        return p;
    endfunction

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
        comparisons++;
        if (got !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic op(input logic [2:0] c, input logic [15:0] d);
        u_mdseq_host.drive(c, 1'b0, d);
    endtask

    task automatic idle(input int n);
        repeat (n) op(3'h1, 16'h0000);
    endtask

    // Issues a code and judges the slot answering the previous read
    task automatic rd(input logic [2:0] c, input logic [15:0] e);
        op(c, 16'h0000);
        #1;
        chk("bus_oe", 16'h0001, {15'h0000, bus_oe});
        chk("bus_out", e, bus_out);
    endtask

    task automatic mul_seq(input logic [2:0] c, input logic [15:0] b, input logic [31:0] e);
        op(c, b);
        idle(7);
        op(3'h7, 16'h0000);
        rd(3'h7, e[31:16]);
        chk("flag", 16'h0000, {15'h0000, range_exceeded_flag});
        rd(3'h1, e[15:0]);
    endtask

    task automatic flag_read(input int n);
        idle(n);
        op(3'h7, 16'h0000);
        op(3'h1, 16'h0000);
        #1;
        chk("bus_oe", 16'h0001, {15'h0000, bus_oe});
        chk("flag", 16'h0001, {15'h0000, range_exceeded_flag});
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_mul();
        logic [31:0] e;
        e = prod(16'h1234, 16'hFEDC);
        op(3'h6, 16'h1234);
        mul_seq(3'h0, 16'hFEDC, e);
        op(3'h6, 16'h1234);
        op(3'h0, 16'hFEDC);
        idle(7);
        op(3'h7, 16'h0000);
        rd(3'h7, e[31:16]);
        rd(3'h7, e[15:0]);
        rd(3'h7, e[15:0]);
        rd(3'h1, e[31:16]);
        $display("t_mul done");
    endtask

    task automatic t_const();
        op(3'h6, 16'h0001);
        op(3'h6, 16'h7FFF);
        op(3'h6, 16'hFFFF);
        op(3'h0, 16'h0001);
        flag_read(7);
        op(3'h6, 16'h0003);
        op(3'h6, 16'h0001);
        op(3'h6, 16'h0000);
        mul_seq(3'h0, 16'h0004, 32'h0001_000C);
        op(3'h5, 16'h4000);
        mul_seq(3'h0, 16'h2000, 32'h1000_0000);
        $display("t_const done");
    endtask

    task automatic t_gate();
        op(3'h6, 16'h0005);
        op(3'h0, 16'h0003);
        idle(7);
        u_mdseq_host.drive(3'h6, 1'b1, 16'hAAAA);
        u_mdseq_host.drive(3'h7, 1'b1, 16'h0000);
        #1;
        chk("bus_oe", 16'h0000, {15'h0000, bus_oe});
        op(3'h7, 16'h0000);
        #1;
        chk("bus_oe", 16'h0000, {15'h0000, bus_oe});
        rd(3'h7, 16'h0000);
        rd(3'h1, 16'h000F);
        mul_seq(3'h0, 16'h0007, 32'h0000_0023);
        $display("t_gate done");
    endtask

    task automatic t_div();
        op(3'h6, 16'h0007);
        op(3'h6, 16'h0001);
        op(3'h4, 16'h0000);
        idle(2);
        op(3'h7, 16'h0000);
        rd(3'h7, 16'h2492);
        rd(3'h1, 16'h0002);
        op(3'h6, 16'h0000);
        op(3'h6, 16'h0000);
        op(3'h4, 16'h0005);
        flag_read(2);
        $display("t_div done");
    endtask

    task automatic t_sum();
        op(3'h6, 16'h0002);
        op(3'h0, 16'h0003);
        idle(6);
        op(3'h6, 16'h0004);
        mul_seq(3'h2, 16'h0005, 32'h0000_001A);
        $display("t_sum done");
    endtask

    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        fails = 0;
        comparisons = 0;
        resetn = 1'b0;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        t_mul();
        t_const();
        t_gate();
        t_div();
        t_sum();
        test_done();
    end

    // Whole run is about 130 cycles; this bound of 5000 cycles leaves wide margin
    initial begin
        #500_000;
        fails++;
        test_done();
    end
endmodule // mdseq_bench
